// ### logic/sgsc_serial_gpio.sv
// sgsc_serial_gpio: serial gpio shift controller with parallel signal
// detect override.
// assumes a board chain of shift registers on the serial pins, async
// pins, and a master on the plain register port at sys_clk.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps

// Summary of operation
// - six parallel detect inputs override the serial detect of a mapped port
// - up to 128 serial bits, as 32 ports of four bits
// - bits shift out on data out, then load strobe applies them
// - data in is sampled while shifting and readable by software
// - only enabled ports are shifted; disabled ports are skipped
// - bits per port is 1 to 4, common to all enabled ports
// - enables and width govern input and output streams alike
// - bursts each end in a load; single burst or repeated with gap
// - a burst never exceeds 32 x 4 data clock cycles
// - repeat gap is 0 to 33 steps of 1 ms, or disabled
// - single burst trigger issues one burst and clears when it ends
// - repeat bursts keeps issuing bursts until software clears it
// - each serial bit takes its value from the port output config
// - shift clock frequency is set by a configuration field
// - load strobe follows every burst and lasts 4 sys_clk cycles, 32 ns
// - load strobe polarity is selectable
// - input and output port order reverse independently
module sgsc_serial_gpio #(
  parameter int unsigned GAP_STEP_CYCLES = sgsc_pkg::GAP_STEP_CYCLES
) (
  // system
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire sgsc_pkg::sgsc_bus_t bus,
  output logic [31:0] rdata,
  // serial chain
  input wire logic serial_data_in,
  output sgsc_pkg::sgsc_pins_t pins,
  // signal detect
  input wire logic [5:0] parallel_signal_detect_in,
  output logic [31:0] port_signal_detect
);
  import sgsc_pkg::*;

  localparam logic [16:0] STEP_LAST = 17'(GAP_STEP_CYCLES - 1);

  sgsc_state_t s;
  sgsc_state_t n;
  logic [7:0] half;

  // ******************************************************************
  // stream position helpers
  // ******************************************************************
  function automatic logic [4:0] port_of(input logic [5:0] w,
                                         input logic rev);
    return rev ? ~w[4:0] : w[4:0];
  endfunction

  function automatic logic [5:0] seek(input logic [31:0] ena,
                                      input logic rev,
                                      input logic [5:0] from);
    logic [5:0] hit;
    hit = 6'h20;
    for (int i = 31; i >= 0; i--)
    begin
      if (6'(i) >= from && ena[port_of(6'(i), rev)])
        hit = 6'(i);
    end
    return hit;
  endfunction

  // ******************************************************************
  // next state
  // ******************************************************************
  always_comb
  begin
    n = s;
    half = (s.shift_clock_frequency < HALF_MIN) ? HALF_MIN
                                                : s.shift_clock_frequency;
    n.sync_di = {s.sync_di[0], serial_data_in};
    n.sd_s1 = parallel_signal_detect_in;
    n.sd_s2 = s.sd_s1;
    n.rdata = 32'h0;

    unique case (s.phase)
      PH_IDLE:
      begin
        if (s.cfg.single_burst_trigger || s.cfg.repeat_bursts)
        begin
          n.out_w = seek(s.serial_port_enable,
                         s.cfg.reverse_output_order, 6'h00);
          n.in_w = seek(s.serial_port_enable,
                        s.cfg.reverse_input_order, 6'h00);
          n.bit_idx = 2'h0;
          n.cnt = 8'h0;
          n.phase = n.out_w[5] ? PH_LOAD : PH_LOW;
        end
      end
      PH_LOW:
      begin
        if (s.cnt == half - 8'h1)
        begin
          n.cnt = 8'h0;
          n.phase = PH_HIGH;
        end
        else
          n.cnt = s.cnt + 8'h1;
      end
      PH_HIGH:
      begin
        if (s.cnt == SAMPLE_AT)
          n.captured_input_bits[{port_of(s.in_w, s.cfg.reverse_input_order),
                                 s.bit_idx}] = s.sync_di[1];
        if (s.cnt == half - 8'h1)
        begin
          n.cnt = 8'h0;
          n.phase = PH_LOW;
          if (s.bit_idx >= s.cfg.bits_per_port)
          begin
            n.bit_idx = 2'h0;
            n.out_w = seek(s.serial_port_enable, s.cfg.reverse_output_order,
                           s.out_w + 6'h1);
            n.in_w = seek(s.serial_port_enable, s.cfg.reverse_input_order,
                          s.in_w + 6'h1);
            if (n.out_w[5])
              n.phase = PH_LOAD;
          end
          else
            n.bit_idx = s.bit_idx + 2'h1;
        end
        else
          n.cnt = s.cnt + 8'h1;
      end
      PH_LOAD:
      begin
        if (s.cnt == LOAD_LAST)
        begin
          n.cnt = 8'h0;
          n.cfg.single_burst_trigger = 1'b0;
          n.gap_ms = 6'h0;
          n.step = 17'h0;
          if (s.cfg.repeat_bursts && !s.cfg.burst_gap_disable &&
              s.cfg.burst_gap_length != 6'h0)
            n.phase = PH_GAP;
          else
            n.phase = PH_IDLE;
        end
        else
          n.cnt = s.cnt + 8'h1;
      end
      PH_GAP:
      begin
        if (s.step == STEP_LAST)
        begin
          n.step = 17'h0;
          if (s.gap_ms + 6'h1 >= s.cfg.burst_gap_length)
            n.phase = PH_IDLE;
          else
            n.gap_ms = s.gap_ms + 6'h1;
        end
        else
          n.step = s.step + 17'h1;
      end
      default:
        n.phase = PH_IDLE;
    endcase

    // register writes come after the sequencer so a write wins
    if (bus.wr)
    begin
      unique case (bus.addr)
        OFS_CFG:
        begin
          n.cfg = bus.wdata[13:0];
          if (bus.wdata[8:3] > GAP_MAX)
            n.cfg.burst_gap_length = GAP_MAX;
        end
        OFS_CLOCK:
          n.shift_clock_frequency = bus.wdata[7:0];
        OFS_PORT_ENA:
          n.serial_port_enable = bus.wdata;
        OFS_SD_MAP:
          n.signal_detect_map_reg = bus.wdata[29:0];
        OFS_SD_ENA:
          n.sd_enable = bus.wdata[5:0];
        default:
        begin
          for (int k = 0; k < 4; k++)
          begin
            if (bus.addr == OFS_OUT_BASE + 8'(4 * k))
              n.port_output_config[32 * k +: 32] = bus.wdata;
          end
        end
      endcase
    end

    if (bus.rd)
    begin
      unique case (bus.addr)
        OFS_CFG:
          n.rdata = {18'h0, s.cfg};
        OFS_CLOCK:
          n.rdata = {24'h0, s.shift_clock_frequency};
        OFS_PORT_ENA:
          n.rdata = s.serial_port_enable;
        OFS_SD_MAP:
          n.rdata = {2'h0, s.signal_detect_map_reg};
        OFS_SD_ENA:
          n.rdata = {26'h0, s.sd_enable};
        OFS_STATUS:
          n.rdata = {29'h0, s.phase};
        OFS_SD_VALUE:
          n.rdata = s.sd_value;
        default:
        begin
          for (int k = 0; k < 4; k++)
          begin
            if (bus.addr == OFS_OUT_BASE + 8'(4 * k))
              n.rdata = s.port_output_config[32 * k +: 32];
            if (bus.addr == OFS_IN_BASE + 8'(4 * k))
              n.rdata = s.captured_input_bits[32 * k +: 32];
          end
        end
      endcase
    end

    // signal detect: serial bit 0 of each port, then parallel overrides
    for (int p = 0; p < 32; p++)
      n.sd_value[p] = s.captured_input_bits[4 * p];
    for (int j = 0; j < 6; j++)
    begin
      if (s.sd_enable[j])
        n.sd_value[s.signal_detect_map_reg[5 * j +: 5]] = s.sd_s2[j];
    end

    // pins follow the next phase so they change with it
    n.pins.serial_shift_clock_out = (n.phase == PH_HIGH);
    n.pins.serial_data_out = 1'b0;
    if (n.phase == PH_LOW || n.phase == PH_HIGH)
      n.pins.serial_data_out =
        n.port_output_config[{port_of(n.out_w,
                                      n.cfg.reverse_output_order),
                              n.bit_idx}];
    n.pins.serial_load_strobe =
      ~((n.phase == PH_LOAD) ^ n.cfg.load_strobe_polarity);
  end

  // ******************************************************************
  // state register
  // ******************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s <= '0;
      s.shift_clock_frequency <= CLK_DIV_RESET;
      s.cfg.load_strobe_polarity <= LD_POL_RESET;
      s.pins.serial_load_strobe <= ~LD_POL_RESET;
    end
    else
      s <= n;
  end

  assign rdata = s.rdata;
  assign pins = s.pins;
  assign port_signal_detect = s.sd_value;

  // ******************************************************************
  // checks
  // ******************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  logic [7:0] burst_bits;
  always_ff @(posedge sys_clk)
  begin
    if (reset || s.phase == PH_IDLE)
      burst_bits <= 8'h0;
    else if (s.phase == PH_HIGH && s.cnt == 8'h0)
      burst_bits <= burst_bits + 8'h1;
  end

  load_width_a: assert property (
    $rose(s.phase == PH_LOAD) |-> (s.phase == PH_LOAD) [*4]
      ##1 (s.phase != PH_LOAD))
    else $error("load strobe length wrong");

  load_pol_a: assert property (
    pins.serial_load_strobe ==
      ((s.phase == PH_LOAD) ? s.cfg.load_strobe_polarity
                            : !s.cfg.load_strobe_polarity) ||
      $changed(s.cfg.load_strobe_polarity))
    else $error("load strobe polarity wrong");

  clk_idle_a: assert property (
    (s.phase == PH_IDLE || s.phase == PH_GAP || s.phase == PH_LOAD)
      |-> !pins.serial_shift_clock_out)
    else $error("shift clock not idle");

  dout_hold_a: assert property (
    (s.phase == PH_HIGH && $past(s.phase) == PH_HIGH &&
     !$past(bus.wr)) |-> $stable(pins.serial_data_out))
    else $error("data out moved while clock high");

  single_clear_a: assert property (
    (s.phase == PH_LOAD && s.cnt == LOAD_LAST && !bus.wr)
      |=> !s.cfg.single_burst_trigger)
    else $error("single burst trigger not cleared");

  repeat_go_a: assert property (
    (s.phase == PH_LOAD && s.cnt == LOAD_LAST && s.cfg.repeat_bursts &&
     s.cfg.burst_gap_disable && !bus.wr)
      |=> (s.phase == PH_IDLE) ##1 (s.phase != PH_IDLE))
    else $error("repeat burst did not restart");

  skip_port_a: assert property (
    (s.phase == PH_LOW && $past(s.phase) != PH_LOW && !$past(bus.wr))
      |-> s.serial_port_enable[port_of(s.out_w,
                                       s.cfg.reverse_output_order)])
    else $error("disabled port shifted");

  burst_len_a: assert property (
    burst_bits <= 8'h80)
    else $error("burst longer than 128 bits");

endmodule

// ### logic/sgsc_pkg.sv
// sgsc_pkg: constants, register map and carrier types of the serial
// gpio shift controller.
// assumes a 125 MHz system clock and a 32-bit plain register port.
package sgsc_pkg;

  // ******************************************************************
  // sizes and timing
  // ******************************************************************
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned PORTS = 32;
  localparam int unsigned BITS_PER_PORT_MAX = 4;
  localparam int unsigned SD_INPUTS = 6;
  localparam int unsigned LOAD_MIN_NS = 25;
  localparam int unsigned LOAD_MAX_NS = 30;
  localparam int unsigned LOAD_CYCLES = (LOAD_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] LOAD_LAST = 8'(LOAD_CYCLES - 1);
  localparam int unsigned GAP_STEP_MS = 1;
  localparam int unsigned GAP_STEP_CYCLES = GAP_STEP_MS * CLK_MHZ * 1000;
  localparam logic [5:0] GAP_MAX = 6'h21;
  localparam logic [7:0] HALF_MIN = 8'h03;
  localparam logic [7:0] SAMPLE_AT = 8'h01;

  // ******************************************************************
  // register offsets and reset values
  // ******************************************************************
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CLOCK = 8'h04;
  localparam logic [7:0] OFS_PORT_ENA = 8'h08;
  localparam logic [7:0] OFS_SD_MAP = 8'h0c;
  localparam logic [7:0] OFS_SD_ENA = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_SD_VALUE = 8'h18;
  localparam logic [7:0] OFS_OUT_BASE = 8'h20;
  localparam logic [7:0] OFS_IN_BASE = 8'h30;
  localparam logic [7:0] CLK_DIV_RESET = 8'h0a;
  localparam logic LD_POL_RESET = 1'b1;

  // ******************************************************************
  // types
  // ******************************************************************
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_LOW = 3'b001,
    PH_HIGH = 3'b010,
    PH_LOAD = 3'b011,
    PH_GAP = 3'b100
  } sgsc_phase_t;

  // bit 0 single_burst_trigger up to bit 13 reverse_output_order
  typedef struct packed {
    logic reverse_output_order;
    logic reverse_input_order;
    logic load_strobe_polarity;
    logic [1:0] bits_per_port;
    logic [5:0] burst_gap_length;
    logic burst_gap_disable;
    logic repeat_bursts;
    logic single_burst_trigger;
  } sgsc_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sgsc_bus_t;

  typedef struct packed {
    logic serial_shift_clock_out;
    logic serial_data_out;
    logic serial_load_strobe;
  } sgsc_pins_t;

  typedef struct packed {
    sgsc_cfg_t cfg;
    logic [7:0] shift_clock_frequency;
    logic [31:0] serial_port_enable;
    logic [29:0] signal_detect_map_reg;
    logic [5:0] sd_enable;
    logic [127:0] port_output_config;
    logic [127:0] captured_input_bits;
    logic [31:0] sd_value;
    logic [31:0] rdata;
    sgsc_phase_t phase;
    logic [7:0] cnt;
    logic [1:0] bit_idx;
    logic [5:0] out_w;
    logic [5:0] in_w;
    logic [5:0] gap_ms;
    logic [16:0] step;
    logic [1:0] sync_di;
    logic [5:0] sd_s1;
    logic [5:0] sd_s2;
    sgsc_pins_t pins;
  } sgsc_state_t;

endpackage

// ### tb/sgsc_chain_model.sv
// sgsc_chain_model: board chain of load-capable shift registers.
// assumes the bench gives load polarity and the parallel input pattern.
`timescale 1ns/1ps
module sgsc_chain_model
  import sgsc_pkg::*;
(
  // serial pins
  input wire sgsc_pkg::sgsc_pins_t pins,
  input wire logic pol,
  output logic serial_data_in,
  // board side
  input wire logic [127:0] in_pat,
  output logic [127:0] out_bits,
  output logic [7:0] out_count
);
  logic [127:0] sh = '0;
  logic [127:0] sr = '0;
  logic [7:0] cnt = '0;
  logic [127:0] ob = '0;
  logic [7:0] oc = '0;
  wire logic act = pins.serial_load_strobe == pol;
  assign serial_data_in = sr[0];
  assign out_bits = ob;
  assign out_count = oc;
  // stages advance on the rise; past the chain end the loaded inputs come back inverted
  // load applies outputs and parallel-loads the inputs
  always @(posedge pins.serial_shift_clock_out or posedge act)
  begin
    if (act)
    begin
      ob <= sh;
      oc <= cnt;
      cnt <= '0;
      sr <= in_pat;
    end
    else
    begin
      sh <= {sh[126:0], pins.serial_data_out};
      cnt <= cnt + 8'h01;
      sr <= {~sr[0], sr[127:1]};
    end
  end
endmodule

// ### tb/tb_top.sv
// tb_top: self-checking bench of the serial gpio shift controller.
// assumes the chain model on the serial pins and a 125 MHz clock.
`timescale 1ns/1ps
module tb_top;
  import sgsc_pkg::*;
  localparam int unsigned GSTEP = 20;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  sgsc_bus_t bus = '0;
  logic [31:0] rdata;
  logic serial_data_in;
  sgsc_pins_t pins;
  logic [5:0] psd = '0;
  logic [31:0] port_sd;
  logic [127:0] in_pat = '0;
  logic [127:0] out_bits;
  logic [7:0] out_count;
  logic pol = 1'b1;
  logic mon_on = 1'b0;
  logic [31:0] lfsr = 32'h53a8;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  int run = 0;
  int hcnt = 0;
  int loads = 0;
  int gap = -1;
  int last_gap = -1;

  always #4 sys_clk = ~sys_clk;

  sgsc_serial_gpio #(.GAP_STEP_CYCLES(GSTEP)) u_dut (
    .sys_clk(sys_clk), .reset(reset), .bus(bus), .rdata(rdata),
    .serial_data_in(serial_data_in), .pins(pins),
    .parallel_signal_detect_in(psd), .port_signal_detect(port_sd));

  sgsc_chain_model u_chain (.pins(pins), .pol(pol),
    .serial_data_in(serial_data_in), .in_pat(in_pat),
    .out_bits(out_bits), .out_count(out_count));

  // ******************************************************************
  // helpers
  // ******************************************************************
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic report_and_stop();
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask

  // model: walk order of (port, bit) positions of one stream
  task automatic order(input logic [31:0] en, input int w,
                       input logic rev, output int q[$]);
    int p;
    q = {};
    for (int pos = 0; pos < 32; pos++)
    begin
      p = rev ? 31 - pos : pos;
      if (en[p])
        for (int b = 0; b < w; b++)
          q.push_back(4 * p + b);
    end
  endtask

  task automatic burst(input logic [31:0] cfg);
    logic [31:0] d;
    int n;
    wr(OFS_CFG, cfg | 32'h1);
    d = 32'h1;
    n = 0;
    while (d[0] === 1'b1 && n < 3000)
    begin
      rd(OFS_CFG, d);
      n++;
    end
    chk(d[0], 1'b0);
  endtask

  // ******************************************************************
  // pin monitor: load width, clock half period, gap, timeout
  // ******************************************************************
  always @(posedge sys_clk)
  begin
    cycles++;
    if (pins.serial_shift_clock_out === 1'b1)
      hcnt++;
    else if (hcnt != 0)
    begin
      chk(hcnt, 5);
      hcnt = 0;
    end
    if (mon_on && pins.serial_load_strobe === pol)
      run++;
    else if (run != 0)
    begin
      chk(run, 4);
      loads++;
      run = 0;
      gap = 0;
    end
    else if (gap >= 0 && pins.serial_shift_clock_out === 1'b1)
    begin
      last_gap = gap;
      gap = -1;
    end
    else if (gap >= 0)
      gap++;
    if (cycles > 100000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  // ******************************************************************
  // main sequence
  // ******************************************************************
  initial
  begin
    logic [31:0] d;
    logic [31:0] en;
    logic [31:0] cfg;
    logic [127:0] oc;
    logic [127:0] ci;
    logic [127:0] ei;
    logic [127:0] mi;
    int qo[$];
    int qi[$];
    int n;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    chk(pins, 3'b000);
    rd(OFS_CFG, d);
    chk(d, 32'h800);
    rd(OFS_CLOCK, d);
    chk(d, 32'h0a);
    rd(8'hfc, d);
    chk(d, 32'h0);
    wr(OFS_CLOCK, 32'h5);
    wr(OFS_CFG, 32'h1f8);
    rd(OFS_CFG, d);
    chk(d, 32'h108);
    for (int t = 0; t < 4; t++)
    begin
      en = (t == 0) ? 32'hffffffff : rnd();
      cfg = (rnd() & 32'h3000) | (t[0] ? 32'h0 : 32'h800) | (t << 9);
      for (int k = 0; k < 4; k++)
      begin
        oc[32 * k +: 32] = rnd();
        wr(OFS_OUT_BASE + 8'(4 * k), oc[32 * k +: 32]);
      end
      in_pat = {rnd(), rnd(), rnd(), rnd()};
      wr(OFS_PORT_ENA, en);
      mon_on = 1'b0;
      wr(OFS_CFG, cfg);
      repeat (3) @(posedge sys_clk);
      pol = cfg[11];
      mon_on = 1'b1;
      burst(cfg);
      burst(cfg);
      order(en, t + 1, cfg[13], qo);
      chk(out_count, qo.size());
      ei = '0;
      foreach (qo[j])
        ei[qo.size() - 1 - j] = oc[qo[j]];
      chk(out_bits & ((128'h1 << qo.size()) - 1), ei);
      order(en, t + 1, cfg[12], qi);
      ei = '0;
      mi = '0;
      foreach (qi[j])
      begin
        ei[qi[j]] = in_pat[j];
        mi[qi[j]] = 1'b1;
      end
      for (int k = 0; k < 4; k++)
        rd(OFS_IN_BASE + 8'(4 * k), ci[32 * k +: 32]);
      chk(ci & mi, ei);
    end
    wr(OFS_SD_MAP, 32'h5);
    wr(OFS_SD_ENA, 32'h1);
    for (int v = 1; v >= 0; v--)
    begin
      psd <= 6'(v);
      repeat (6) @(posedge sys_clk);
      chk(port_sd[5], v[0]);
      rd(OFS_SD_VALUE, d);
      chk(d[5], v[0]);
    end
    wr(OFS_PORT_ENA, 32'h1);
    for (int gd = 0; gd < 2; gd++)
    begin
      mon_on = 1'b0;
      wr(OFS_CFG, 32'h800);
      repeat (3) @(posedge sys_clk);
      pol = 1'b1;
      mon_on = 1'b1;
      loads = 0;
      wr(OFS_CFG, 32'h81a | (gd << 2));
      n = 0;
      while (loads < 3 && n < 2000)
      begin
        @(posedge sys_clk);
        n++;
      end
      chk(loads >= 3, 1'b1);
      chk(last_gap >= (gd ? 0 : 60) && last_gap <= (gd ? 16 : 76), 1);
      wr(OFS_CFG, 32'h800);
      repeat (200) @(posedge sys_clk);
      n = loads;
      repeat (200) @(posedge sys_clk);
      chk(loads, n);
      rd(OFS_STATUS, d);
      chk(d, 32'h0);
    end
    report_and_stop();
  end
endmodule
